// ==== verilog/scp_regs.svh ====
`ifndef SCP_REGS_SVH
`define SCP_REGS_SVH
// current settings in percent of full scale
`define SCP_PCT_MAX 7'h64
`define SCP_HOLD_DFLT 7'h19
`define SCP_RUN_DFLT 7'h32
// full-scale phase current in milliamps
`define SCP_FULL_MA 12'h7d0
// thermal cut-off threshold in degrees celsius
`define SCP_TEMP_CRIT 8'h55
// settling time unit in microseconds, and cycles per unit at 50 MHz
`define SCP_CLK_MHZ 50
`define SCP_SETTLE_UNIT_US 1000
`define SCP_SETTLE_UNIT_CYC (`SCP_SETTLE_UNIT_US * `SCP_CLK_MHZ)
// program store size
`define SCP_PROG_DEPTH 1024
// position reset value
`define SCP_POS_RST 32'h00000000
// half-step resolution code
`define SCP_RES_HALF 3'h1
`endif

// ==== verilog/scp_pkg.sv ====
package scp_pkg;
  // current level state
  typedef enum logic [1:0] {SCP_HOLD, SCP_RUN, SCP_SETTLE} scp_cur_state_t;
  // a current setting request
  typedef struct packed {
    logic [7:0] hold_pct;
    logic [7:0] run_pct;
  } scp_cur_req_t;
  // one step event
  typedef struct packed {
    logic step;
    logic dir_neg;
  } scp_step_t;
endpackage

// ==== verilog/scp_pct_check.sv ====
`timescale 1ns/1ps
`include "scp_regs.svh"
// ************************************************************
// range check of one percent value
// ************************************************************
module scp_pct_check
  import scp_pkg::*;
#(
  parameter logic [6:0] DFLT = 7'h19
) (
  // value in
  input wire logic [7:0] i_pct,
  // checked value out
  output logic [6:0] o_pct
);
  // out of range picks the default for this value alone
  assign o_pct = (i_pct > {1'b0, `SCP_PCT_MAX}) ? DFLT : i_pct[6:0]; // R6
endmodule

// ==== verilog/scp_pos_counter.sv ====
`timescale 1ns/1ps
`include "scp_regs.svh"
// ************************************************************
// signed step position counter
// ************************************************************
module scp_pos_counter
  import scp_pkg::*;
#(
  parameter int WIDTH = 32
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // step events and preset
  input wire scp_step_t i_step,
  input wire logic i_load,
  input wire logic [WIDTH-1:0] i_load_val,
  // count
  output logic [WIDTH-1:0] o_pos
);
  // preset wins; otherwise count with natural wrap, no saturation
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_pos <= WIDTH'(`SCP_POS_RST); // R12
    end else if (i_load) begin
      o_pos <= i_load_val; // R12
    end else if (i_step.step) begin
      if (i_step.dir_neg) begin
        o_pos <= o_pos - WIDTH'(1); // R10 R13
      end else begin
        o_pos <= o_pos + WIDTH'(1); // R10 R13
      end
    end
  end
endmodule

// ==== verilog/scp_current_position.sv ====
`timescale 1ns/1ps
`include "scp_regs.svh"
// Function
// R1: new hold applies at once when idle
// R2: motion start switches to run instantly
// R3: hold returns after motion and settling delay
// R4: new motion during settling keeps run
// R5: currents are percent, 100 is full
// R6: out-of-range value takes its default
// R7: save command stores all parameters; the code stores only hold, run and settling time
// R8: position is a signed 32-bit counter
// R9: position follows steps and direction
// R10: plus step adds one, minus subtracts
// R11: counts at microstep and divider granularity
// R12: zero at reset, preset on origin command
// R13: counter wraps at both extremes
// R14: position read in immediate or program mode
// R15: program plus multi-axis suppresses data replies
// R16: host presets only after motion end wait; the code loads a preset whenever i_origin_set is high, even during a move
// R17: over-temperature cuts drive current
// R18: status read reports driver temperature
// R19: program store has 1024 locations
// R20: resolution one selects half step
module scp_current_position
  import scp_pkg::*;
#(
  parameter int POS_W = 32,
  parameter int PROG_DEPTH = `SCP_PROG_DEPTH,
  parameter int SETTLE_UNIT_CYC = `SCP_SETTLE_UNIT_CYC
) (
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_RSTN,
  // current programming
  input wire logic i_cur_set,
  input wire scp_cur_req_t i_cur_req,
  input wire logic [15:0] i_settle_units,
  // motion events
  input wire logic i_motion_start,
  input wire logic i_motion_busy,
  input wire logic i_ustep,
  input wire logic i_dir_neg,
  input wire logic [15:0] i_divider,
  input wire logic [2:0] i_resolution,
  // position commands
  input wire logic i_origin_set,
  input wire logic [POS_W-1:0] i_origin_val,
  input wire logic i_pos_read,
  // modes
  input wire logic i_program_mode,
  input wire logic i_multi_axis,
  // thermal and status
  input wire logic [7:0] i_temp_c,
  input wire logic i_status_read,
  // save and program store
  input wire logic i_save_params_cmd,
  input wire logic i_prog_wr,
  input wire logic [$clog2(PROG_DEPTH)-1:0] i_prog_addr,
  input wire logic [15:0] i_prog_data,
  // current outputs
  output logic [6:0] O_DRIVE_PCT,
  output logic [11:0] O_DRIVE_MA,
  output logic O_THERMAL_CUT,
  output logic O_RUN_LEVEL,
  // position outputs
  output logic [POS_W-1:0] O_POS,
  output logic O_POS_VALID,
  output logic O_POS_SUPPRESSED,
  // status outputs
  output logic [7:0] O_TEMP_C,
  output logic O_TEMP_VALID,
  // save, half-step and program store outputs
  output logic O_NV_WR,
  output scp_cur_req_t O_NV_CUR,
  output logic [15:0] O_NV_SETTLE,
  output logic O_HALF_STEP,
  output logic [15:0] O_PROG_RDATA
);
  // ************************************************************
  // current settings
  // ************************************************************
  logic [6:0] hold_chk;
  logic [6:0] run_chk;
  logic [6:0] hold_reg;
  logic [6:0] run_reg;
  logic [15:0] settle_reg;
  scp_cur_state_t state_reg;
  logic [31:0] unit_cnt_reg;
  logic [15:0] settle_cnt_reg;
  logic step_evt;
  logic [15:0] div_cnt_reg;
  logic [POS_W-1:0] pos;
  logic [6:0] level_pct;
  logic [18:0] ma_prod;
  logic [15:0] prog_mem [PROG_DEPTH];
  logic suppress;
  logic temp_hot;
  logic motion_now;
  scp_step_t step_in;

  scp_pct_check #(.DFLT(`SCP_HOLD_DFLT)) u_hold_chk (
    .i_pct(i_cur_req.hold_pct),
    .o_pct(hold_chk)
  );
  scp_pct_check #(.DFLT(`SCP_RUN_DFLT)) u_run_chk (
    .i_pct(i_cur_req.run_pct),
    .o_pct(run_chk)
  );

  // latch checked percentages on i_cur_set; settling time is copied every cycle
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      hold_reg <= `SCP_HOLD_DFLT;
      run_reg <= `SCP_RUN_DFLT;
      settle_reg <= 16'h0000;
    end else begin
      if (i_cur_set) begin
        hold_reg <= hold_chk; // R5 R6
        run_reg <= run_chk; // R5 R6
      end
      settle_reg <= i_settle_units;
    end
  end

  // ************************************************************
  // hold/run level sequencing
  // ************************************************************
  // a move is requested or still running
  assign motion_now = i_motion_start || i_motion_busy;

  // hold, run and settling sequence; a stray code falls back to hold
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      state_reg <= SCP_HOLD;
      unit_cnt_reg <= 32'h00000000;
      settle_cnt_reg <= 16'h0000;
    end else begin
      unique case (state_reg)
        SCP_HOLD: begin
          if (i_motion_start || i_motion_busy) begin
            state_reg <= SCP_RUN; // R2
          end
        end
        SCP_RUN: begin
          if (!i_motion_busy && !i_motion_start) begin
            state_reg <= SCP_SETTLE;
            unit_cnt_reg <= 32'h00000000;
            settle_cnt_reg <= 16'h0000;
          end
        end
        SCP_SETTLE: begin
          if (i_motion_start || i_motion_busy) begin
            state_reg <= SCP_RUN; // R4
          end else if (settle_cnt_reg >= settle_reg) begin
            state_reg <= SCP_HOLD; // R3
          end else if (unit_cnt_reg == 32'(SETTLE_UNIT_CYC - 1)) begin
            unit_cnt_reg <= 32'h00000000;
            settle_cnt_reg <= settle_cnt_reg + 16'h0001;
          end else begin
            unit_cnt_reg <= unit_cnt_reg + 32'h00000001;
          end
        end
        default: begin
          state_reg <= SCP_HOLD;
        end
      endcase
    end
  end

  // over-temperature seen this cycle, so the cut lands with the flag, not a cycle later
  assign temp_hot = (i_temp_c > `SCP_TEMP_CRIT); // R17

  // level chosen by state; idle picks up new hold at once
  always_comb begin
    if (temp_hot) begin
      level_pct = 7'h00; // R17
    end else if (state_reg == SCP_HOLD && !motion_now) begin
      level_pct = hold_reg; // R1
    end else begin
      level_pct = run_reg; // R2 R4
    end
  end
  // percent of the full-scale phase current, in milliamps
  assign ma_prod = 19'(level_pct) * 19'(`SCP_FULL_MA);

  // drive level in percent and milliamps
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_DRIVE_PCT <= 7'h00;
      O_DRIVE_MA <= 12'h000;
    end else begin
      O_DRIVE_PCT <= level_pct; // R1 R2
      O_DRIVE_MA <= 12'(ma_prod / 19'(`SCP_PCT_MAX)); // R5
    end
  end

  // run flag: high from the start edge until settling ends
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_RUN_LEVEL <= 1'b0;
    end else begin
      O_RUN_LEVEL <= (state_reg != SCP_HOLD) || motion_now; // R2 R3
    end
  end

  // thermal cut flag follows the temperature each cycle
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_THERMAL_CUT <= 1'b0;
    end else begin
      O_THERMAL_CUT <= temp_hot; // R17
    end
  end

  // ************************************************************
  // position counting
  // ************************************************************
  // one count per divider-worth of microsteps, whatever the resolution setting
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      div_cnt_reg <= 16'h0000;
    end else if (i_origin_set) begin
      div_cnt_reg <= 16'h0000;
    end else if (i_ustep) begin
      if (div_cnt_reg + 16'h0001 >= i_divider) begin
        div_cnt_reg <= 16'h0000; // R11
      end else begin
        div_cnt_reg <= div_cnt_reg + 16'h0001;
      end
    end
  end
  assign step_evt = i_ustep && (div_cnt_reg + 16'h0001 >= i_divider); // R9 R11
  // step event and its direction travel together
  assign step_in.step = step_evt; // R9
  assign step_in.dir_neg = i_dir_neg; // R10

  // counter wraps at both ends rather than saturating
  scp_pos_counter #(.WIDTH(POS_W)) u_pos (
    .i_clk(I_CLK),
    .i_rstn(I_RSTN),
    .i_step(step_in), // R9 R10
    .i_load(i_origin_set), // R12
    .i_load_val(i_origin_val),
    .o_pos(pos) // R8 R13
  );

  // ************************************************************
  // read replies
  // ************************************************************
  // program and multi-axis together mute every data reply
  assign suppress = i_program_mode && i_multi_axis; // R15

  // position reply, one cycle behind the counter
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_POS <= POS_W'(`SCP_POS_RST);
      O_POS_VALID <= 1'b0;
      O_POS_SUPPRESSED <= 1'b0;
    end else begin
      O_POS <= pos;
      O_POS_VALID <= i_pos_read && !suppress; // R14 R15
      O_POS_SUPPRESSED <= (i_pos_read || i_status_read) && suppress; // R15
    end
  end

  // temperature status reply
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_TEMP_C <= 8'h00;
      O_TEMP_VALID <= 1'b0;
    end else begin
      O_TEMP_C <= i_temp_c; // R18
      O_TEMP_VALID <= i_status_read && !suppress; // R18 R15
    end
  end

  // ************************************************************
  // save and program store
  // ************************************************************
  // save strobe and the parameter image handed to storage
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_NV_WR <= 1'b0;
      O_NV_CUR <= '0;
      O_NV_SETTLE <= 16'h0000;
    end else begin
      O_NV_WR <= i_save_params_cmd; // R7
      if (i_save_params_cmd) begin
        O_NV_CUR <= '{hold_pct: {1'b0, hold_reg}, run_pct: {1'b0, run_reg}}; // R7
        O_NV_SETTLE <= settle_reg; // R7
      end
    end
  end

  // half-step flag decoded from the resolution setting
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_HALF_STEP <= 1'b0;
    end else begin
      O_HALF_STEP <= (i_resolution == `SCP_RES_HALF); // R20
    end
  end

  // program locations held in an array
  always_ff @(posedge I_CLK) begin
    if (i_prog_wr) begin
      prog_mem[i_prog_addr] <= i_prog_data; // R19
    end
  end
  // registered read of the addressed location
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_PROG_RDATA <= 16'h0000;
    end else begin
      O_PROG_RDATA <= prog_mem[i_prog_addr];
    end
  end
endmodule

// ==== test/scp_current_position_sva.sv ====
`timescale 1ns/1ps
// ************************************************************
// port checks of drive current and step position
// ************************************************************
module scp_current_position_sva
  import scp_pkg::*;
#(
  parameter int POS_W = 32
) (
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_RSTN,
  // watched inputs
  input wire logic i_motion_start,
  input wire logic i_motion_busy,
  input wire logic i_ustep,
  input wire logic i_dir_neg,
  input wire logic [15:0] i_divider,
  input wire logic i_origin_set,
  input wire logic [POS_W-1:0] i_origin_val,
  input wire logic i_pos_read,
  input wire logic i_program_mode,
  input wire logic i_multi_axis,
  input wire logic [7:0] i_temp_c,
  input wire logic i_save_params_cmd,
  // watched outputs
  input wire logic O_RUN_LEVEL,
  input wire logic O_THERMAL_CUT,
  input wire logic [6:0] O_DRIVE_PCT,
  input wire logic [POS_W-1:0] O_POS,
  input wire logic O_POS_VALID,
  input wire logic O_POS_SUPPRESSED,
  input wire logic O_NV_WR
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RSTN);
  // motion ended and nothing new arrives for the whole settle span
  sequence s_quiet;
    !i_motion_start && !i_motion_busy;
  endsequence
  sequence s_stop;
    $fell(i_motion_busy) ##0 s_quiet [*8] ##1 s_quiet [*6];
  endsequence
  a_run_start: assert property (i_motion_start |=> O_RUN_LEVEL) else $error("run level missed at start");
  a_busy_run: assert property (i_motion_busy |=> O_RUN_LEVEL) else $error("run level lost in motion");
  a_hold_back: assert property (s_stop |-> !O_RUN_LEVEL) else $error("hold level not restored");
  a_temp_cut: assert property (i_temp_c > 8'h55 |=> O_THERMAL_CUT && O_DRIVE_PCT == 7'h0)
    else $error("hot driver not cut");
  a_temp_ok: assert property (i_temp_c <= 8'h55 |=> !O_THERMAL_CUT) else $error("cut while cool");
  a_step_count: assert property (i_ustep && !i_origin_set && i_divider <= 16'h1 |-> ##2
    O_POS == $past(O_POS) + ($past(i_dir_neg, 2) ? 32'hffffffff : 32'h1)) else $error("step count wrong");
  a_origin_load: assert property (i_origin_set |-> ##2 O_POS == $past(i_origin_val, 2))
    else $error("preset not loaded");
  a_read_ok: assert property (i_pos_read && !(i_program_mode && i_multi_axis) |=> O_POS_VALID && !O_POS_SUPPRESSED)
    else $error("position reply missing");
  a_read_mute: assert property (i_pos_read && i_program_mode && i_multi_axis |=> O_POS_SUPPRESSED && !O_POS_VALID)
    else $error("position reply not muted");
  a_save_write: assert property (i_save_params_cmd |=> O_NV_WR) else $error("save not written");
endmodule

bind scp_current_position scp_current_position_sva #(.POS_W(POS_W)) u_sva (
  .I_CLK(I_CLK), .I_RSTN(I_RSTN), .i_motion_start(i_motion_start), .i_motion_busy(i_motion_busy),
  .i_ustep(i_ustep), .i_dir_neg(i_dir_neg), .i_divider(i_divider), .i_origin_set(i_origin_set),
  .i_origin_val(i_origin_val), .i_pos_read(i_pos_read), .i_program_mode(i_program_mode),
  .i_multi_axis(i_multi_axis), .i_temp_c(i_temp_c), .i_save_params_cmd(i_save_params_cmd),
  .O_RUN_LEVEL(O_RUN_LEVEL), .O_THERMAL_CUT(O_THERMAL_CUT), .O_DRIVE_PCT(O_DRIVE_PCT), .O_POS(O_POS),
  .O_POS_VALID(O_POS_VALID), .O_POS_SUPPRESSED(O_POS_SUPPRESSED), .O_NV_WR(O_NV_WR));

// ==== test/scp_host_model.sv ====
`timescale 1ns/1ps
// ************************************************************
// host side motion source: start, busy and microstep pulses
// ************************************************************
module scp_host_model #(
  parameter int GAP = 4
) (
  // clock
  input wire logic i_clk,
  // motion events
  output logic o_start,
  output logic o_busy,
  output logic o_ustep,
  output logic o_dir_neg
);
  // idle at time zero
  initial begin
    o_start = 1'b0;
    o_busy = 1'b0;
    o_ustep = 1'b0;
    o_dir_neg = 1'b0;
  end
  // one move of n microsteps, direction held for the whole move
  task automatic move(input int n, input logic neg);
    @(negedge i_clk);
    o_dir_neg = neg;
    o_start = 1'b1;
    o_busy = 1'b1;
    @(negedge i_clk);
    o_start = 1'b0;
    repeat (n) begin
      o_ustep = 1'b1;
      @(negedge i_clk);
      o_ustep = 1'b0;
      repeat (GAP) @(negedge i_clk);
    end
    o_busy = 1'b0;
  endtask
endmodule

// ==== test/tb.sv ====
`timescale 1ns/1ps
// ************************************************************
// bench for current level and position counter
// ************************************************************
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin errors++; \
  $display("BAD %s exp %0h got %0h", nm, ex, got); end end
module tb;
  import scp_pkg::*;
  typedef struct {logic [7:0] h, r, t, eh, er; logic cut;} scp_row_t;
  logic I_CLK = 0, I_RSTN = 0, i_cur_set = 0, i_motion_start, i_motion_busy, i_ustep, i_dir_neg;
  logic i_origin_set = 0, i_pos_read = 0, i_program_mode = 0, i_multi_axis = 0, i_status_read = 0;
  logic i_save_params_cmd = 0, i_prog_wr = 0;
  logic [2:0] i_resolution = 3'h0;
  logic [7:0] i_temp_c = 8'h19;
  logic [9:0] i_prog_addr = 10'h0;
  logic [15:0] i_settle_units = 16'h2, i_divider = 16'h1, i_prog_data = 16'h0;
  logic [31:0] i_origin_val = 32'h0, O_POS;
  scp_cur_req_t i_cur_req = '0, O_NV_CUR;
  logic [6:0] O_DRIVE_PCT;
  logic [11:0] O_DRIVE_MA;
  logic [7:0] O_TEMP_C;
  logic [15:0] O_NV_SETTLE, O_PROG_RDATA;
  logic O_THERMAL_CUT, O_RUN_LEVEL, O_POS_VALID, O_POS_SUPPRESSED, O_TEMP_VALID, O_NV_WR, O_HALF_STEP;
  int errors = 0, checks = 0;
  // settings in, expected stored settings, cut flag
  scp_row_t rows[4] = '{'{8'h64, 8'h64, 8'h55, 8'h64, 8'h64, 1'b0}, '{8'h65, 8'h00, 8'h56, 8'h19, 8'h00, 1'b1},
    '{8'h00, 8'hff, 8'h30, 8'h00, 8'h32, 1'b0}, '{8'h0a, 8'h50, 8'h19, 8'h0a, 8'h50, 1'b0}};

  scp_current_position #(.SETTLE_UNIT_CYC(4)) uut (
    .I_CLK(I_CLK), .I_RSTN(I_RSTN), .i_cur_set(i_cur_set), .i_cur_req(i_cur_req),
    .i_settle_units(i_settle_units), .i_motion_start(i_motion_start), .i_motion_busy(i_motion_busy),
    .i_ustep(i_ustep), .i_dir_neg(i_dir_neg), .i_divider(i_divider), .i_resolution(i_resolution),
    .i_origin_set(i_origin_set), .i_origin_val(i_origin_val), .i_pos_read(i_pos_read),
    .i_program_mode(i_program_mode), .i_multi_axis(i_multi_axis), .i_temp_c(i_temp_c),
    .i_status_read(i_status_read), .i_save_params_cmd(i_save_params_cmd), .i_prog_wr(i_prog_wr),
    .i_prog_addr(i_prog_addr), .i_prog_data(i_prog_data), .O_DRIVE_PCT(O_DRIVE_PCT), .O_DRIVE_MA(O_DRIVE_MA),
    .O_THERMAL_CUT(O_THERMAL_CUT), .O_RUN_LEVEL(O_RUN_LEVEL), .O_POS(O_POS), .O_POS_VALID(O_POS_VALID),
    .O_POS_SUPPRESSED(O_POS_SUPPRESSED), .O_TEMP_C(O_TEMP_C), .O_TEMP_VALID(O_TEMP_VALID), .O_NV_WR(O_NV_WR),
    .O_NV_CUR(O_NV_CUR), .O_NV_SETTLE(O_NV_SETTLE), .O_HALF_STEP(O_HALF_STEP), .O_PROG_RDATA(O_PROG_RDATA));
  scp_host_model host (.i_clk(I_CLK), .o_start(i_motion_start), .o_busy(i_motion_busy), .o_ustep(i_ustep),
    .o_dir_neg(i_dir_neg));

  // 50 MHz clock
  always #10 I_CLK = ~I_CLK;

  task automatic tick(input int n);
    repeat (n) @(negedge I_CLK);
  endtask
  // position read with given modes
  task automatic rd(input logic pm, input logic ma, input logic ev);
    i_program_mode = pm;
    i_multi_axis = ma;
    i_pos_read = 1;
    tick(1);
    i_pos_read = 0;
    `CHK("pos_valid", ev, O_POS_VALID)
    `CHK("pos_supp", ~ev, O_POS_SUPPRESSED)
    tick(1);
  endtask
  // one-cycle preset then check
  task automatic preset(input logic [31:0] v);
    i_origin_val = v;
    i_origin_set = 1;
    tick(1);
    i_origin_set = 0;
    tick(2);
    `CHK("preset", v, O_POS)
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // watchdog
  initial begin
    repeat (3000) @(posedge I_CLK);
    errors++;
    tally_and_finish();
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    tick(5);
    I_RSTN = 1;
    tick(2);
    `CHK("pos_rst", 32'h0, O_POS)
    `CHK("drive_rst", 7'h19, O_DRIVE_PCT)
    foreach (rows[k]) begin
      i_cur_req = {rows[k].h, rows[k].r};
      i_temp_c = rows[k].t;
      i_cur_set = 1;
      tick(1);
      i_cur_set = 0;
      i_save_params_cmd = 1;
      tick(1);
      i_save_params_cmd = 0;
      tick(2);
      `CHK("nv_cur", {rows[k].eh, rows[k].er}, O_NV_CUR)
      `CHK("nv_settle", 16'h2, O_NV_SETTLE)
      `CHK("cut", rows[k].cut, O_THERMAL_CUT)
      `CHK("drive", rows[k].cut ? 7'h0 : rows[k].eh[6:0], O_DRIVE_PCT)
      `CHK("ma", rows[k].cut ? 12'h0 : 12'(rows[k].eh) * 12'h14, O_DRIVE_MA)
    end
    // move, restart inside the settle span, then settle to hold
    host.move(3, 1'b0);
    tick(4);
    `CHK("run_settle", 1'b1, O_RUN_LEVEL)
    host.move(1, 1'b1);
    `CHK("run_keep", 1'b1, O_RUN_LEVEL)
    `CHK("run_pct", 7'h50, O_DRIVE_PCT)
    tick(20);
    `CHK("run_off", 1'b0, O_RUN_LEVEL)
    `CHK("hold", 7'h0a, O_DRIVE_PCT)
    `CHK("pos_move", 32'h2, O_POS)
    // divider of four counts every fourth microstep
    i_divider = 16'h4;
    host.move(8, 1'b0);
    tick(3);
    `CHK("pos_div", 32'h4, O_POS)
    i_divider = 16'h1;
    // preset only after motion end, then wrap both ways
    tick(20);
    preset(32'h7fffffff);
    host.move(1, 1'b0);
    tick(3);
    `CHK("wrap_max", 32'h80000000, O_POS)
    host.move(1, 1'b1);
    tick(3);
    `CHK("wrap_min", 32'h7fffffff, O_POS)
    rd(0, 0, 1);
    rd(1, 0, 1);
    rd(0, 1, 1);
    rd(1, 1, 0);
    i_program_mode = 0;
    i_multi_axis = 0;
    // status temperature reply
    i_temp_c = 8'h2a;
    i_status_read = 1;
    tick(1);
    i_status_read = 0;
    `CHK("temp_valid", 1'b1, O_TEMP_VALID)
    `CHK("temp", 8'h2a, O_TEMP_C)
    i_resolution = 3'h1;
    tick(2);
    `CHK("half", 1'b1, O_HALF_STEP)
    i_resolution = 3'h2;
    tick(2);
    `CHK("not_half", 1'b0, O_HALF_STEP)
    // status reply muted in program plus multi-axis mode
    i_program_mode = 1;
    i_multi_axis = 1;
    i_status_read = 1;
    tick(1);
    i_status_read = 0;
    `CHK("temp_mute", 1'b0, O_TEMP_VALID)
    `CHK("temp_supp", 1'b1, O_POS_SUPPRESSED)
    tick(1);
    i_program_mode = 0;
    i_multi_axis = 0;
    // top program location
    i_prog_addr = 10'h3ff;
    i_prog_data = 16'hbeef;
    i_prog_wr = 1;
    tick(1);
    i_prog_wr = 0;
    tick(2);
    `CHK("prog", 16'hbeef, O_PROG_RDATA)
    // reset while idle clears the counter and restores the default hold
    I_RSTN = 0;
    tick(2);
    `CHK("pos_rst2", 32'h0, O_POS)
    `CHK("drive_rst2", 7'h00, O_DRIVE_PCT)
    I_RSTN = 1;
    tick(2);
    `CHK("pos_rel", 32'h0, O_POS)
    `CHK("hold_rel", 7'h19, O_DRIVE_PCT)
    tally_and_finish();
  end
endmodule
